// [src/tksync_pkg.sv]
// Purpose: shared constants for the transport key and sync offset block
// Assumes: 250 MHz mclk_i, key codes carried as 6-bit row/column words
// Notes:   times are kept in their own unit, cycle counts derive from them
package tksync_pkg;
    localparam int CLK_MHZ        = 250;
    localparam int POLL_TIME_US   = 1000;
    localparam int POLL_CYCLES    = POLL_TIME_US * CLK_MHZ;
    localparam int FRAME_TIME_US  = 33330;
    localparam int FRAME_CYCLES   = FRAME_TIME_US * CLK_MHZ;
    localparam int STEP_TIME_US   = 416;
    localparam int STEP_CYCLES    = STEP_TIME_US * CLK_MHZ;

    localparam logic [2:0]  RD_CYCLES   = 3'h4;
    localparam logic [7:0]  SCAN_DWELL  = 8'h40;
    localparam logic [6:0]  SUB_MAX     = 7'h4f;
    localparam logic [23:0] PHASE_TOL   = 24'h0000fa;
    localparam logic [23:0] WIND_FRAMES = 24'h00004b;

    localparam int KEY_VALID_BIT = 7;
    localparam logic [5:0] KEY_STOP    = 6'h00;
    localparam logic [5:0] KEY_PLAY    = 6'h01;
    localparam logic [5:0] KEY_RECORD  = 6'h02;
    localparam logic [5:0] KEY_FFWD    = 6'h03;
    localparam logic [5:0] KEY_REWIND  = 6'h04;
    localparam logic [5:0] KEY_SHUTTLE = 6'h08;

    localparam logic [1:0] WIND_NONE = 2'h0;
    localparam logic [1:0] WIND_FWD  = 2'h1;
    localparam logic [1:0] WIND_REW  = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_KBD  = 3'b010,
        ST_REM  = 3'b100
    } tksync_state_t;
endpackage

// [src/tksync_top.sv]
// Purpose: key polling, command serving and time code offset lock control
// Assumes: time code words and sync pulses come from logic on mclk_i
// Notes:   one poll reads the local encoder, then the built-in remote one
`timescale 1ns/1ps
// Operation
// - local key encoder words read over an 8-bit parallel bus
// - tape end sensor gates acceptance of every transport key command
// - shuttle touch holds the encoder's return line zero low like a key
// - shuttle word read samples wheel voltage for reel shuttle control
// - remote matrix scanned continuously, key found where drive returns
// - remote encoder read by chip select together with read strobe
// - remote encoder polled once per roughly one millisecond cycle
// - remote play lights the remote play lamp and sends play mode
// - local and remote commands served in fixed poll order, local first
// - compare reference and playback time code, decide lock
// - while unlocked trim play speed or choose a wind direction
// - playback compared against reference value plus frame offset
// - frame offset resolution is one whole frame, about 33.33 ms
// - sub-frame offset uses only sync pulse phase, not code values
// - sub-frame value 0 to 79, applied on top of the frame offset
// - sub-frame steps are one eightieth frame, either direction
module tksync_top #(
    parameter int POLL_CYC  = tksync_pkg::POLL_CYCLES,
    parameter int FRAME_CYC = tksync_pkg::FRAME_CYCLES,
    parameter int STEP_CYC  = tksync_pkg::STEP_CYCLES
) (
    input  wire logic        mclk_i,
    input  wire logic        srst_i,
    output logic             kbd_cs_n_o,
    output logic             kbd_rd_n_o,
    input  wire logic [7:0]  kbd_data_i,
    input  wire logic        touch_i,
    output logic             touch_return_line_n_o,
    input  wire logic [7:0]  wheel_pos_i,
    output logic [7:0]       shuttle_pos_o,
    output logic             shuttle_active_o,
    input  wire logic        tape_end_sensor_i,
    output logic [7:0]       scan_drive_o,
    input  wire logic [7:0]  return_i,
    output logic             rem_cs_o,
    output logic             rem_rd_o,
    output logic             play_lamp_o,
    output logic             cmd_valid_o,
    output logic [5:0]       cmd_code_o,
    output logic             cmd_remote_o,
    output logic             mode_strobe_o,
    output logic [5:0]       mode_o,
    input  wire logic [23:0] ref_frames_i,
    input  wire logic [23:0] play_frames_i,
    input  wire logic        play_valid_i,
    input  wire logic        ref_sync_i,
    input  wire logic        play_sync_i,
    input  wire logic [23:0] frame_offset_i,
    input  wire logic [6:0]  subframe_i,
    input  wire logic        subframe_dir_i,
    output logic             locked_o,
    output logic             speed_up_o,
    output logic             speed_down_o,
    output logic [1:0]       wind_o
);
    localparam logic [23:0] POLL_LAST = 24'(POLL_CYC - 1);
    localparam logic [23:0] FRAME_C   = 24'(FRAME_CYC);
    localparam logic [23:0] STEP_C    = 24'(STEP_CYC);

    // two-flop synchronisers for pin inputs; first stage read only here
    logic [7:0] kbd_m, kbd_s, wheel_m, wheel_s, ret_m, ret_s;
    logic       touch_m, touch_s, eot_m, eot_s;
    always_ff @(posedge mclk_i) begin
        kbd_m   <= kbd_data_i;
        kbd_s   <= kbd_m;
        wheel_m <= wheel_pos_i;
        wheel_s <= wheel_m;
        ret_m   <= return_i;
        ret_s   <= ret_m;
        touch_m <= touch_i;
        touch_s <= touch_m;
        eot_m   <= tape_end_sensor_i;
        eot_s   <= eot_m;
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            touch_return_line_n_o <= 1'b1;
        end else begin
            touch_return_line_n_o <= ~touch_s;
        end
    end
    // remote matrix scanner
    logic [2:0] row;
    logic [7:0] dwell;
    logic [7:0] rem_word;
    logic [5:0] last_code;
    logic       last_ok, seen;
    logic [2:0] col;
    logic       hit, rem_take;
    always_comb begin
        col = 3'h0;
        hit = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            if (ret_s[i]) begin
                col = 3'(i);
                hit = 1'b1;
            end
        end
    end
    assign scan_drive_o = 8'h01 << row;
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            row       <= 3'h0;
            dwell     <= 8'h00;
            rem_word  <= 8'h00;
            last_code <= 6'h00;
            last_ok   <= 1'b0;
            seen      <= 1'b0;
        end else begin
            if (rem_take) begin
                rem_word[tksync_pkg::KEY_VALID_BIT] <= 1'b0;
            end
            if (dwell == tksync_pkg::SCAN_DWELL) begin
                dwell <= 8'h00;
                row   <= row + 3'h1;
                if (hit) begin
                    seen <= 1'b1;
                    // a held key reports once; set wins over the read
                    if (!(last_ok && last_code == {row, col})) begin
                        rem_word  <= {2'b10, row, col};
                        last_code <= {row, col};
                        last_ok   <= 1'b1;
                    end
                end else if (row == 3'h7) begin
                    seen <= 1'b0;
                    if (!seen) begin
                        last_ok <= 1'b0;
                    end
                end
            end else begin
                dwell <= dwell + 8'h01;
            end
        end
    end
    // polling sequencer
    tksync_pkg::tksync_state_t st;
    logic [23:0] poll_cnt;
    logic [2:0]  rd_cnt;
    logic        poll_tick, rd_end;
    assign poll_tick = (poll_cnt == POLL_LAST);
    assign rd_end    = (rd_cnt == tksync_pkg::RD_CYCLES - 3'h1);
    assign rem_take  = (st == tksync_pkg::ST_REM) && rd_end;
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            poll_cnt <= 24'h000000;
        end else if (poll_tick) begin
            poll_cnt <= 24'h000000;
        end else begin
            poll_cnt <= poll_cnt + 24'h000001;
        end
    end
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            st     <= tksync_pkg::ST_IDLE;
            rd_cnt <= 3'h0;
        end else begin
            case (st)
                tksync_pkg::ST_IDLE: begin
                    rd_cnt <= 3'h0;
                    if (poll_tick) begin
                        st <= tksync_pkg::ST_KBD;
                    end
                end
                tksync_pkg::ST_KBD: begin
                    rd_cnt <= rd_end ? 3'h0 : rd_cnt + 3'h1;
                    if (rd_end) begin
                        st <= tksync_pkg::ST_REM;
                    end
                end
                tksync_pkg::ST_REM: begin
                    rd_cnt <= rd_end ? 3'h0 : rd_cnt + 3'h1;
                    if (rd_end) begin
                        st <= tksync_pkg::ST_IDLE;
                    end
                end
                default: begin
                    st <= tksync_pkg::ST_IDLE;
                end
            endcase
        end
    end
    // strobes held for the whole read so the synchronised data settles
    assign kbd_cs_n_o = (st != tksync_pkg::ST_KBD);
    assign kbd_rd_n_o = (st != tksync_pkg::ST_KBD);
    assign rem_cs_o   = (st == tksync_pkg::ST_REM);
    assign rem_rd_o   = (st == tksync_pkg::ST_REM);
    // one word taken per read, local read before remote in every poll
    logic [7:0] take_word;
    logic       take_remote, take_valid, is_transport, accept;
    always_comb begin
        take_remote = (st == tksync_pkg::ST_REM);
        take_word   = take_remote ? rem_word : kbd_s;
        take_valid  = rd_end && (st != tksync_pkg::ST_IDLE)
                      && take_word[tksync_pkg::KEY_VALID_BIT];
        is_transport = take_word[5:0] <= tksync_pkg::KEY_REWIND;
        accept = take_valid && (!is_transport || eot_s);
    end
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            cmd_valid_o   <= 1'b0;
            cmd_code_o    <= 6'h00;
            cmd_remote_o  <= 1'b0;
            mode_strobe_o <= 1'b0;
            mode_o        <= tksync_pkg::KEY_STOP;
            play_lamp_o   <= 1'b0;
        end else begin
            cmd_valid_o   <= accept;
            mode_strobe_o <= accept && is_transport;
            if (accept) begin
                cmd_code_o   <= take_word[5:0];
                cmd_remote_o <= take_remote;
            end
            if (accept && is_transport) begin
                mode_o      <= take_word[5:0];
                play_lamp_o <= take_remote
                    && take_word[5:0] == tksync_pkg::KEY_PLAY;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            shuttle_pos_o    <= 8'h00;
            shuttle_active_o <= 1'b0;
        end else if (take_valid && !take_remote) begin
            shuttle_active_o <= take_word[5:0] == tksync_pkg::KEY_SHUTTLE;
            if (take_word[5:0] == tksync_pkg::KEY_SHUTTLE) begin
                shuttle_pos_o <= wheel_s;
            end
        end
    end

    // synchroniser: frame offset on code values, sub-frame on phase only
    logic [23:0] phase_cnt, phase_meas, target, sub_cyc, want;
    logic [6:0]  sub_eff;
    logic signed [24:0] fdiff, perr;
    always_comb begin
        sub_eff = (subframe_i > tksync_pkg::SUB_MAX)
                  ? tksync_pkg::SUB_MAX : subframe_i;
        sub_cyc = 24'({17'h00000, sub_eff} * STEP_C);
        want    = subframe_dir_i ? sub_cyc
                  : ((sub_cyc == 24'h000000) ? 24'h000000
                     : FRAME_C - sub_cyc);
        target  = ref_frames_i + frame_offset_i;
        fdiff   = $signed({1'b0, play_frames_i})
                  - $signed({1'b0, target});
        perr    = $signed({1'b0, phase_meas})
                  - $signed({1'b0, want});
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            phase_cnt  <= 24'h000000;
            phase_meas <= 24'h000000;
        end else begin
            phase_cnt <= ref_sync_i ? 24'h000000 : phase_cnt + 24'h000001;
            if (play_sync_i) begin
                phase_meas <= phase_cnt;
            end
        end
    end

    logic signed [24:0] wind_lim, tol;
    assign wind_lim = $signed({1'b0, tksync_pkg::WIND_FRAMES});
    assign tol      = $signed({1'b0, tksync_pkg::PHASE_TOL});

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            locked_o     <= 1'b0;
            speed_up_o   <= 1'b0;
            speed_down_o <= 1'b0;
            wind_o       <= tksync_pkg::WIND_NONE;
        end else if (play_valid_i) begin
            locked_o     <= 1'b0;
            speed_up_o   <= 1'b0;
            speed_down_o <= 1'b0;
            wind_o       <= tksync_pkg::WIND_NONE;
            if (fdiff > wind_lim) begin
                wind_o <= tksync_pkg::WIND_REW;
            end else if (fdiff < -wind_lim) begin
                wind_o <= tksync_pkg::WIND_FWD;
            end else if (fdiff != 25'sh0000000) begin
                speed_down_o <= fdiff > 25'sh0000000;
                speed_up_o   <= fdiff < 25'sh0000000;
            end else if (perr > tol) begin
                speed_up_o <= 1'b1;
            end else if (perr < -tol) begin
                speed_down_o <= 1'b1;
            end else begin
                locked_o <= 1'b1;
            end
        end
    end

    a_poll_start: assert property (@(posedge mclk_i) disable iff (srst_i)
        st == tksync_pkg::ST_IDLE && poll_tick |=> st == tksync_pkg::ST_KBD)
        else $error("poll did not start on tick");
    a_kbd_strobe: assert property (@(posedge mclk_i) disable iff (srst_i)
        $rose(!kbd_cs_n_o) |-> (!kbd_rd_n_o) [*4] ##1 kbd_rd_n_o)
        else $error("local read strobe length wrong");
    a_rem_strobe: assert property (@(posedge mclk_i) disable iff (srst_i)
        rem_take |-> rem_cs_o && rem_rd_o && $past(!kbd_cs_n_o, 4))
        else $error("remote read not after local read");
    a_tape_gate: assert property (@(posedge mclk_i) disable iff (srst_i)
        mode_strobe_o |-> $past(eot_s))
        else $error("transport key taken while gated");
    a_touch_line: assert property (@(posedge mclk_i) disable iff (srst_i)
        $past(touch_s) && !$past(srst_i) |-> !touch_return_line_n_o)
        else $error("touch return line not low");
    a_shuttle_pos: assert property (@(posedge mclk_i) disable iff (srst_i)
        take_valid && !take_remote
        && take_word[5:0] == tksync_pkg::KEY_SHUTTLE
        |=> shuttle_active_o && shuttle_pos_o == $past(wheel_s))
        else $error("wheel position not sampled");
    a_remote_play: assert property (@(posedge mclk_i) disable iff (srst_i)
        accept && take_remote && take_word[5:0] == tksync_pkg::KEY_PLAY
        |=> play_lamp_o && mode_o == tksync_pkg::KEY_PLAY && cmd_remote_o)
        else $error("remote play not served");
    a_scan_onehot: assert property (@(posedge mclk_i) disable iff (srst_i)
        $onehot(scan_drive_o) && (dwell != 8'h00 || $changed(row)
        || $past(srst_i)))
        else $error("scan drive not one-hot or stalled");
    a_sub_clamp: assert property (@(posedge mclk_i) disable iff (srst_i)
        sub_eff <= 7'h4f && want < FRAME_C)
        else $error("sub-frame offset out of range");
    a_lock_excl: assert property (@(posedge mclk_i) disable iff (srst_i)
        $rose(locked_o) |-> $past(fdiff) == 25'sh0000000
        && !speed_up_o && !speed_down_o && wind_o == tksync_pkg::WIND_NONE)
        else $error("lock without frame match");
endmodule

// [testbench/tksync_partner.sv]
// Purpose: local key encoder and remote key matrix seen from the block
// Assumes: one word waits in the encoder until the controller reads it
// Notes:   an unselected data bus toggles so a stale word is never seen
`timescale 1ns/1ps
module tksync_partner (
    input  wire logic       mclk_i,
    input  wire logic       cs_n_i,
    input  wire logic       ld_i,
    input  wire logic [7:0] w_i,
    output logic [7:0]      data_o,
    input  wire logic [7:0] scan_i,
    input  wire logic [2:0] row_i,
    input  wire logic [2:0] col_i,
    input  wire logic       down_i,
    output logic [7:0]      ret_o
);
    logic [7:0] held = 8'h00;
    logic [7:0] alt  = 8'h55;
    logic       cs_q = 1'b1;
    // a read pops the word, as the encoder queue does
    always_ff @(posedge mclk_i) begin
        cs_q <= cs_n_i;
        alt  <= ~alt;
        if (ld_i)
            held <= w_i;
        else if (cs_n_i && !cs_q)
            held[7] <= 1'b0;
    end
    assign data_o = !cs_n_i ? held : alt;
    // drive comes back only on the pressed key's return line
    assign ret_o = (down_i && scan_i[row_i]) ? (8'h01 << col_i) : 8'h00;
endmodule

// [testbench/test_tksync_top.sv]
// Purpose: self-checking bench for key polling and sync offset lock
// Assumes: short counts POLL 40, FRAME 800, STEP 10 cycles
// Notes:   expected lock results come from the integer model smodel below
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
 $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module test_tksync_top;
    localparam int PC = 40, FC = 800, SC = 10;
    logic mclk_i = 1'b0, srst_i = 1'b1, touch_i = 1'b0, te = 1'b1;
    logic ld = 1'b0, down = 1'b0, pv = 1'b0, rs = 1'b0, ps = 1'b0, dir = 1'b0;
    logic [7:0] wd = 8'h00, wheel = 8'h00, kd, ret, scan;
    logic [2:0] row = 3'h0, col = 3'h0;
    logic [23:0] rf = 24'h0, pf = 24'h0, off = 24'h0;
    logic [6:0] sub = 7'h0;
    logic kcs, krd, trl, sact, rcs, rrd, lamp, cv, crem, mst, lk, su, sd;
    logic [7:0] spos;
    logic [5:0] ccode, mode;
    logic [1:0] wind;
    int error_cnt = 0, n_checks = 0, cyc = 0, seed = 32'hd3b27484, t;
    bit got;
    int dl[4] = '{100, -100, 3, -3};
    always #2 mclk_i = ~mclk_i;
    tksync_top #(.POLL_CYC(PC), .FRAME_CYC(FC), .STEP_CYC(SC)) tksync_top_inst (
        .mclk_i(mclk_i), .srst_i(srst_i), .kbd_cs_n_o(kcs), .kbd_rd_n_o(krd),
        .kbd_data_i(kd), .touch_i(touch_i), .touch_return_line_n_o(trl),
        .wheel_pos_i(wheel), .shuttle_pos_o(spos), .shuttle_active_o(sact),
        .tape_end_sensor_i(te), .scan_drive_o(scan), .return_i(ret),
        .rem_cs_o(rcs), .rem_rd_o(rrd), .play_lamp_o(lamp), .cmd_valid_o(cv),
        .cmd_code_o(ccode), .cmd_remote_o(crem), .mode_strobe_o(mst),
        .mode_o(mode), .ref_frames_i(rf), .play_frames_i(pf),
        .play_valid_i(pv), .ref_sync_i(rs), .play_sync_i(ps),
        .frame_offset_i(off), .subframe_i(sub), .subframe_dir_i(dir),
        .locked_o(lk), .speed_up_o(su), .speed_down_o(sd), .wind_o(wind));
    tksync_partner tksync_partner_inst (.mclk_i(mclk_i), .cs_n_i(kcs),
        .ld_i(ld), .w_i(wd), .data_o(kd), .scan_i(scan), .row_i(row),
        .col_i(col), .down_i(down), .ret_o(ret));
    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 30000) begin
            error_cnt++;
            complete_run();
        end
    end
    task automatic tick(int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    task automatic wait_cmd(int lim);
        got = 0;
        for (int k = 0; k < lim && !got; k++) begin
            tick(1);
            got = (cv === 1'b1);
        end
    endtask
    task automatic load(logic [7:0] w);
        // a word landing mid-read would be popped unread, so wait it out
        do tick(1); while (kcs !== 1'b1);
        @(posedge mclk_i);
        ld <= 1'b1;
        wd <= w;
        @(posedge mclk_i);
        ld <= 1'b0;
    endtask
    // expected lock state {locked, up, down, wind} from frames and phase
    function automatic logic [4:0] smodel(int fd, int meas, int s, bit d);
        int w, e;
        if (fd > 75) return {3'b000, tksync_pkg::WIND_REW};
        if (fd < -75) return {3'b000, tksync_pkg::WIND_FWD};
        if (fd > 0) return {3'b001, tksync_pkg::WIND_NONE};
        if (fd < 0) return {3'b010, tksync_pkg::WIND_NONE};
        s = (s > 79) ? 79 : s;
        w = (s == 0) ? 0 : (d ? s * SC : FC - s * SC);
        e = meas - w;
        if (e > 250) return {3'b010, tksync_pkg::WIND_NONE};
        if (e < -250) return {3'b001, tksync_pkg::WIND_NONE};
        return {3'b100, tksync_pkg::WIND_NONE};
    endfunction
    task automatic sync_case(int fd, int s, bit d, int gap);
        int r;
        r = 1000 + ($random(seed) & 16'hffff);
        @(posedge mclk_i);
        off <= 24'($random(seed) & 16'h03ff);
        rf <= 24'(r);
        sub <= 7'(s);
        dir <= d;
        rs <= 1'b1;
        @(posedge mclk_i);
        rs <= 1'b0;
        pf <= 24'(r + fd) + off;
        repeat (gap - 1) @(posedge mclk_i);
        ps <= 1'b1;
        @(posedge mclk_i);
        ps <= 1'b0;
        pv <= 1'b1;
        @(posedge mclk_i);
        pv <= 1'b0;
        tick(3);
        `CHK({lk, su, sd, wind}, smodel(fd, gap, s, d))
    endtask
    initial begin
        repeat (20) @(posedge mclk_i);
        srst_i <= 1'b0;
        for (int c = 0; c < 5; c++) begin
            load({2'h2, 6'(c)});
            wait_cmd(200);
            `CHK({got, mst, crem, ccode}, {3'b110, 6'(c)})
            tick(3);
            `CHK(mode, 6'(c))
        end
        @(posedge mclk_i);
        te <= 1'b0;
        load({2'h2, tksync_pkg::KEY_PLAY});
        wait_cmd(200);
        `CHK(got, 1'b0)
        $display("test local keys done");
        @(posedge mclk_i);
        te <= 1'b1;
        touch_i <= 1'b1;
        tick(5);
        `CHK(trl, 1'b0)
        @(posedge mclk_i);
        touch_i <= 1'b0;
        tick(5);
        `CHK(trl, 1'b1)
        @(posedge mclk_i);
        wheel <= 8'($random(seed));
        load({2'h2, tksync_pkg::KEY_SHUTTLE});
        tick(120);
        `CHK({sact, spos}, {1'b1, wheel})
        $display("test shuttle done");
        @(posedge mclk_i);
        row <= 3'h0;
        col <= 3'h1;
        down <= 1'b1;
        wait_cmd(1500);
        `CHK({got, crem, ccode}, {2'b11, tksync_pkg::KEY_PLAY})
        tick(3);
        `CHK({lamp, mode}, {1'b1, tksync_pkg::KEY_PLAY})
        @(posedge mclk_i);
        down <= 1'b0;
        while (rcs !== 1'b1) tick(1);
        `CHK({rrd, kcs, krd}, 3'b111)
        while (rcs !== 1'b0) tick(1);
        for (t = 1; rcs !== 1'b1 && t < 200; t++) tick(1);
        `CHK(t, PC - 3)
        tick(700);
        $display("test remote done");
        load({2'h2, tksync_pkg::KEY_FFWD});
        col <= 3'h0;
        down <= 1'b1;
        wait_cmd(200);
        `CHK({got, crem, ccode}, {2'b10, tksync_pkg::KEY_FFWD})
        wait_cmd(1500);
        `CHK({got, crem, ccode}, {2'b11, tksync_pkg::KEY_STOP})
        @(posedge mclk_i);
        down <= 1'b0;
        tick(3);
        `CHK(lamp, 1'b0)
        $display("test order done");
        foreach (dl[i]) sync_case(dl[i], 5, 1'b1, 50);
        for (int d = 0; d < 2; d++) begin
            t = 1 + (($random(seed) & 32'h7fffffff) % 79);
            sync_case(0, t, d[0], d ? t * SC : FC - t * SC);
            sync_case(0, t, d[0], (d ? t * SC : FC - t * SC) + 300);
        end
        sync_case(0, 100, 1'b1, 790);
        sync_case(0, 0, 1'b0, 5);
        $display("test sync done");
        complete_run();
    end
endmodule
